// ### rtl/phase_ocp_regs.svh
/*
  register offsets, field positions, reset values and timing figures of the phase
  limiter and measurement monitor. assumes inclusion by bare name.
*/
`ifndef PHASE_OCP_REGS_SVH
`define PHASE_OCP_REGS_SVH

`define OFS_GAIN_LOW 8'h21
`define OFS_GAIN_HIGH 8'h22
`define OFS_SUM_DELAY 8'h23
`define OFS_SUM_THRESHOLD 8'h24
`define OFS_FAULT_STATUS 8'h2a
`define OFS_PHASE_FLAGS 8'h2b
`define OFS_CURRENT_RESULT 8'h2e
`define OFS_VOLTAGE_RESULT 8'h2f
`define OFS_THERMAL_RESULT 8'h30
`define OFS_CURRENT_WINDOW 8'h31
`define OFS_VOLTAGE_WINDOW 8'h32
`define OFS_THERMAL_WINDOW 8'h33
`define OFS_LIMIT_DISABLE 8'h4d

`define RST_REG8 8'h00
`define RST_GAIN 8'h80
`define BIT_SUM_FAULT 2
`define DIS_OFF 2'h0

// times in ns
`define CLK_PERIOD_NS 10
`define COMPARE_DELAY_NS 100
`define SLOW_INTERVAL_NS 40500
`define FAST_INTERVAL_NS 13500
`define BOOST_INTERVAL_NS 6750
`define COMPARE_DELAY_CYC (`COMPARE_DELAY_NS / `CLK_PERIOD_NS)
`define SLOW_INTERVAL_CYC (`SLOW_INTERVAL_NS / `CLK_PERIOD_NS)
`define FAST_INTERVAL_CYC (`FAST_INTERVAL_NS / `CLK_PERIOD_NS)
`define BOOST_INTERVAL_CYC (`BOOST_INTERVAL_NS / `CLK_PERIOD_NS)

// sum fault deglitch, in conversions of the current channel
`define SUM_DELAY_0 4'h1
`define SUM_DELAY_1 4'h2
`define SUM_DELAY_2 4'h4
`define SUM_DELAY_3 4'h8

`endif

// ### rtl/phase_ocp_pkg.sv
/*
  types shared by the phase limiter and measurement monitor.
  assumes the offsets and figures of phase_ocp_regs.svh.
*/
package phase_ocp_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef enum {
    conv_idle,
    conv_run
  } conv_state_t;
endpackage

// ### rtl/delay_line.sv
/*
  fixed delay of a bit vector, standing in for comparator response time.
  assumes a single clk domain.
*/
`timescale 1ns/1ps
module delay_line #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 10
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage [DEPTH];
  logic [WIDTH-1:0] next_stage [DEPTH];

  always_comb begin
    next_stage[0] = din;
    for (int i = 1; i < DEPTH; i++) begin
      next_stage[i] = stage[i-1];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < DEPTH; i++) begin
        stage[i] <= '0;
      end
    end else begin
      stage <= next_stage;
    end
  end

  assign dout = stage[DEPTH-1];
endmodule // delay_line

// ### rtl/avg_filter.sv
/*
  running average of an 8-bit sample, window 1/2/4/8 samples picked by sel.
  assumes one valid pulse per new sample.
*/
`timescale 1ns/1ps
module avg_filter (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // sample in
  input wire logic valid,
  input wire logic [7:0] sample,
  input wire logic [1:0] sel,
  // average out
  output logic [7:0] avg
);
  logic [10:0] acc;
  logic [10:0] next_acc;
  logic [7:0] next_avg;

  // exponential average; shift of sel sets the window
  always_comb begin
    next_acc = acc;
    next_avg = avg;
    if (valid) begin
      next_acc = acc - (acc >> sel) + {3'h0, sample};
      next_avg = 8'((acc - (acc >> sel) + {3'h0, sample}) >> sel);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc <= '0;
      avg <= '0;
    end else begin
      acc <= next_acc;
      avg <= next_avg;
    end
  end
endmodule // avg_filter

// ### rtl/phase_ocp_adc_monitor.sv
/*
  per-phase valley limiter and periodic measurement monitor with its registers.
  assumes a digitised sample source (converter handshake) and pin inputs that
  are asynchronous; register access comes through the documented register port.
*/
// How it works
// - a phase above its valley limit may not start a new pulse cycle
// - per-phase limit gain comes from two 8-bit gain registers
// - flag bit set while that phase current exceeds its limit
// - flag follows the comparator live, no latching
// - flag and block update about 120 ns after the crossing
// - power good stays high during per-phase limiting
// - nonzero two-bit disable field turns per-phase limiting off
// - converter idles until power good has gone high
// - voltage and thermal inputs converted every 40.5 us
// - current monitor converted every 13.5 us normally
// - current, voltage, thermal results at three consecutive offsets
// - each result averaged over a window its own two-bit field selects
// - after sum fault trips, current conversion interval becomes 6.75 us
// - sum fault deglitch taken from a two-bit field
// - each raw current conversion (not the averaged result) compared with six-bit sum threshold
// - persistent sum fault tri-states pulses, drops power good, latches flag
`timescale 1ns/1ps
`include "phase_ocp_regs.svh"
module phase_ocp_adc_monitor #(
  parameter int PHASES = 8,
  parameter int SLOW_CYC = `SLOW_INTERVAL_CYC,
  parameter int FAST_CYC = `FAST_INTERVAL_CYC,
  parameter int BOOST_CYC = `BOOST_INTERVAL_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire phase_ocp_pkg::reg_req_t req,
  output logic [7:0] rdata,
  // phase comparators, one per phase, high when current above limit
  input wire logic [PHASES-1:0] phase_sensed_current_high,
  output logic [15:0] limit_gain,
  // pulse control
  input wire logic [PHASES-1:0] pulse_request,
  output logic [PHASES-1:0] pulse_start,
  output logic pulse_tristate,
  // power good
  input wire logic regulation_ok,
  output logic power_good_output,
  // converter
  output logic conv_start,
  output logic [1:0] conv_channel,
  input wire logic conv_done,
  input wire logic [7:0] conv_data
);
  // two-stage synchronisers for pin inputs
  logic [PHASES-1:0] cmp_meta, cmp_sync;
  logic ok_meta, ok_sync;
  logic [PHASES-1:0] cmp_delayed;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmp_meta <= '0;
      cmp_sync <= '0;
      ok_meta <= 1'b0;
      ok_sync <= 1'b0;
    end else begin
      cmp_meta <= phase_sensed_current_high;
      cmp_sync <= cmp_meta;
      ok_meta <= regulation_ok;
      ok_sync <= ok_meta;
    end
  end

  // comparator response time
  delay_line #(
    .WIDTH(PHASES),
    .DEPTH(`COMPARE_DELAY_CYC)
  ) u_cmp_delay (
    .clk(clk),
    .rstn(rstn),
    .din(cmp_sync),
    .dout(cmp_delayed)
  );

  // registers
  logic [7:0] gain_low, gain_high, sum_delay, sum_threshold;
  logic [7:0] cur_window, volt_window, therm_window, limit_disable;
  logic [7:0] next_gain_low, next_gain_high, next_sum_delay, next_sum_threshold;
  logic [7:0] next_cur_window, next_volt_window, next_therm_window, next_limit_disable;

  always_comb begin
    next_gain_low = gain_low;
    next_gain_high = gain_high;
    next_sum_delay = sum_delay;
    next_sum_threshold = sum_threshold;
    next_cur_window = cur_window;
    next_volt_window = volt_window;
    next_therm_window = therm_window;
    next_limit_disable = limit_disable;
    if (req.wr) begin
      case (req.addr)
        `OFS_GAIN_LOW: next_gain_low = req.wdata;
        `OFS_GAIN_HIGH: next_gain_high = req.wdata;
        `OFS_SUM_DELAY: next_sum_delay = req.wdata;
        `OFS_SUM_THRESHOLD: next_sum_threshold = req.wdata;
        `OFS_CURRENT_WINDOW: next_cur_window = req.wdata;
        `OFS_VOLTAGE_WINDOW: next_volt_window = req.wdata;
        `OFS_THERMAL_WINDOW: next_therm_window = req.wdata;
        `OFS_LIMIT_DISABLE: next_limit_disable = req.wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gain_low <= `RST_GAIN;
      gain_high <= `RST_GAIN;
      sum_delay <= `RST_REG8;
      sum_threshold <= `RST_REG8;
      cur_window <= `RST_REG8;
      volt_window <= `RST_REG8;
      therm_window <= `RST_REG8;
      limit_disable <= `RST_REG8;
    end else begin
      gain_low <= next_gain_low;
      gain_high <= next_gain_high;
      sum_delay <= next_sum_delay;
      sum_threshold <= next_sum_threshold;
      cur_window <= next_cur_window;
      volt_window <= next_volt_window;
      therm_window <= next_therm_window;
      limit_disable <= next_limit_disable;
    end
  end

  assign limit_gain = {gain_high, gain_low};

  // per-phase limiting
  logic limit_enabled;
  logic [7:0] phase_flags;
  assign limit_enabled = (limit_disable[1:0] == `DIS_OFF);

  always_comb begin
    phase_flags = '0;
    for (int i = 0; i < PHASES && i < 8; i++) begin
      phase_flags[i] = cmp_delayed[i];
    end
  end

  logic sum_fault;
  always_comb begin
    for (int i = 0; i < PHASES; i++) begin
      pulse_start[i] = pulse_request[i] && !sum_fault
        && !(limit_enabled && cmp_delayed[i]);
    end
  end

  // power good ignores per-phase limiting
  assign power_good_output = ok_sync && !sum_fault;
  assign pulse_tristate = sum_fault;

  // conversion scheduler
  phase_ocp_pkg::conv_state_t state, next_state;
  logic [15:0] cur_timer, slow_timer, next_cur_timer, next_slow_timer;
  logic slow_sel, next_slow_sel;
  logic cur_pend, slow_pend, next_cur_pend, next_slow_pend;
  logic busy, next_busy;
  logic [1:0] chan, next_chan;
  logic [15:0] cur_reload;

  assign cur_reload = sum_fault ? 16'(BOOST_CYC - 1) : 16'(FAST_CYC - 1);

  always_comb begin
    next_state = state;
    next_cur_timer = cur_timer;
    next_slow_timer = slow_timer;
    next_slow_sel = slow_sel;
    next_cur_pend = cur_pend;
    next_slow_pend = slow_pend;
    next_busy = busy;
    next_chan = chan;
    conv_start = 1'b0;
    case (state)
      phase_ocp_pkg::conv_idle: begin
        if (ok_sync) begin
          next_state = phase_ocp_pkg::conv_run;
          next_cur_pend = 1'b1;
          next_slow_pend = 1'b1;
          next_cur_timer = cur_reload;
          // half interval: voltage and thermal alternate, each every SLOW_CYC
          next_slow_timer = 16'((SLOW_CYC / 2) - 1);
        end
      end
      phase_ocp_pkg::conv_run: begin
        if (cur_timer == 16'h0000) begin
          next_cur_timer = cur_reload;
          next_cur_pend = 1'b1;
        end else begin
          next_cur_timer = cur_timer - 16'h0001;
        end
        // voltage and thermal interleave, each every second tick
        if (slow_timer == 16'h0000) begin
          next_slow_timer = 16'((SLOW_CYC / 2) - 1);
          next_slow_pend = 1'b1;
        end else begin
          next_slow_timer = slow_timer - 16'h0001;
        end
        if (busy) begin
          if (conv_done) begin
            next_busy = 1'b0;
          end
        end else if (cur_pend) begin
          conv_start = 1'b1;
          next_chan = 2'h0;
          next_busy = 1'b1;
          next_cur_pend = 1'b0;
        end else if (slow_pend) begin
          conv_start = 1'b1;
          next_chan = slow_sel ? 2'h2 : 2'h1;
          next_slow_sel = !slow_sel;
          next_busy = 1'b1;
          next_slow_pend = 1'b0;
        end
      end
      default: next_state = phase_ocp_pkg::conv_idle;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= phase_ocp_pkg::conv_idle;
      cur_timer <= '0;
      slow_timer <= '0;
      slow_sel <= 1'b0;
      cur_pend <= 1'b0;
      slow_pend <= 1'b0;
      busy <= 1'b0;
      chan <= 2'h0;
    end else begin
      state <= next_state;
      cur_timer <= next_cur_timer;
      slow_timer <= next_slow_timer;
      slow_sel <= next_slow_sel;
      cur_pend <= next_cur_pend;
      slow_pend <= next_slow_pend;
      busy <= next_busy;
      chan <= next_chan;
    end
  end

  assign conv_channel = conv_start ? next_chan : chan;

  // averaging per channel
  logic [2:0] ch_valid;
  logic [7:0] avg [3];
  logic [1:0] win [3];
  assign win[0] = cur_window[1:0];
  assign win[1] = volt_window[1:0];
  assign win[2] = therm_window[1:0];

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_avg
      assign ch_valid[g] = busy && conv_done && (chan == 2'(g));
      avg_filter u_avg (
        .clk(clk),
        .rstn(rstn),
        .valid(ch_valid[g]),
        .sample(conv_data),
        .sel(win[g]),
        .avg(avg[g])
      );
    end
  endgenerate

  // sum fault deglitch
  function automatic logic [3:0] delay_count(input logic [1:0] code);
    case (code)
      2'h0: delay_count = `SUM_DELAY_0;
      2'h1: delay_count = `SUM_DELAY_1;
      2'h2: delay_count = `SUM_DELAY_2;
      default: delay_count = `SUM_DELAY_3;
    endcase
  endfunction

  logic [3:0] over_count, next_over_count;
  logic next_sum_fault;
  always_comb begin
    next_over_count = over_count;
    next_sum_fault = sum_fault;
    if (ch_valid[0]) begin
      if (conv_data > {2'h0, sum_threshold[5:0]}) begin
        next_over_count = over_count + 4'h1;
        if (over_count + 4'h1 >= delay_count(sum_delay[1:0])) begin
          next_sum_fault = 1'b1;
        end
      end else begin
        next_over_count = 4'h0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      over_count <= '0;
      sum_fault <= 1'b0;
    end else begin
      over_count <= next_over_count;
      sum_fault <= next_sum_fault;
    end
  end

  // read mux
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    if (req.rd) begin
      case (req.addr)
        `OFS_GAIN_LOW: next_rdata = gain_low;
        `OFS_GAIN_HIGH: next_rdata = gain_high;
        `OFS_SUM_DELAY: next_rdata = sum_delay;
        `OFS_SUM_THRESHOLD: next_rdata = sum_threshold;
        `OFS_FAULT_STATUS: next_rdata = 8'(sum_fault) << `BIT_SUM_FAULT;
        `OFS_PHASE_FLAGS: next_rdata = phase_flags;
        `OFS_CURRENT_RESULT: next_rdata = avg[0];
        `OFS_VOLTAGE_RESULT: next_rdata = avg[1];
        `OFS_THERMAL_RESULT: next_rdata = avg[2];
        `OFS_CURRENT_WINDOW: next_rdata = cur_window;
        `OFS_VOLTAGE_WINDOW: next_rdata = volt_window;
        `OFS_THERMAL_WINDOW: next_rdata = therm_window;
        `OFS_LIMIT_DISABLE: next_rdata = limit_disable;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end
endmodule // phase_ocp_adc_monitor

// ### tb/phase_ocp_adc_monitor_checker.sv
/*
  port assertions for phase_ocp_adc_monitor.
  assumes a bind onto the design and its single clk domain.
*/
`timescale 1ns/1ps
`include "phase_ocp_regs.svh"
module phase_ocp_adc_monitor_checker #(
  parameter int PHASES = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire phase_ocp_pkg::reg_req_t req,
  input wire logic [7:0] rdata,
  // limiter
  input wire logic [PHASES-1:0] phase_sensed_current_high,
  input wire logic [PHASES-1:0] pulse_request,
  input wire logic [PHASES-1:0] pulse_start,
  input wire logic pulse_tristate,
  // power good and converter
  input wire logic regulation_ok,
  input wire logic power_good_output,
  input wire logic conv_start
);
  logic lim_on, next_lim_on, pg_seen, next_pg_seen;
  logic [3:0] hi_cnt, next_hi_cnt, lo_cnt, next_lo_cnt;

  // age of phase 1 comparator level, disable field as written
  always_comb begin
    next_lim_on = lim_on;
    if (req.wr && req.addr == `OFS_LIMIT_DISABLE) begin
      next_lim_on = req.wdata[1:0] == `DIS_OFF;
    end
    next_pg_seen = pg_seen | power_good_output;
    next_hi_cnt = 4'h0;
    next_lo_cnt = 4'h0;
    if (phase_sensed_current_high[0]) begin
      next_hi_cnt = hi_cnt == 4'hf ? hi_cnt : hi_cnt + 4'h1;
    end else begin
      next_lo_cnt = lo_cnt == 4'hf ? lo_cnt : lo_cnt + 4'h1;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lim_on <= 1'b1;
      pg_seen <= 1'b0;
      hi_cnt <= 4'h0;
      lo_cnt <= 4'h0;
    end else begin
      lim_on <= next_lim_on;
      pg_seen <= next_pg_seen;
      hi_cnt <= next_hi_cnt;
      lo_cnt <= next_lo_cnt;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_reg_good;
    regulation_ok [*4] ##0 !pulse_tristate;
  endsequence
  sequence s_fault_set;
    !pulse_tristate ##1 pulse_tristate;
  endsequence

  a_start_needs_req: assert property ((pulse_start & ~pulse_request) == '0)
    else $error("pulse start without request");
  a_limit_blocks: assert property (lim_on && hi_cnt >= 4'he |-> !pulse_start[0])
    else $error("phase 1 started over its limit");
  a_limit_releases: assert property (
    lim_on && lo_cnt >= 4'he && pulse_request[0] && !pulse_tristate |-> pulse_start[0])
    else $error("phase 1 held after current fell");
  a_limit_off: assert property (
    !lim_on && pulse_request[0] && !pulse_tristate |-> pulse_start[0])
    else $error("phase 1 held while limiting disabled");
  a_pg_during_limit: assert property (s_reg_good |-> power_good_output)
    else $error("power good low without fault");
  a_conv_idle: assert property (!(pg_seen || power_good_output) |-> !conv_start)
    else $error("conversion before power good");
  a_fault_outputs: assert property (
    pulse_tristate |-> pulse_start == '0 && !power_good_output)
    else $error("fault without pulse stop");
  a_fault_sticky: assert property (s_fault_set |=> pulse_tristate [*8])
    else $error("sum fault did not hold");
  a_read_idle: assert property (!req.rd |=> rdata == 8'h00)
    else $error("read data without read");
endmodule // phase_ocp_adc_monitor_checker

bind phase_ocp_adc_monitor phase_ocp_adc_monitor_checker #(.PHASES(PHASES)) chk (
  .clk(clk), .rstn(rstn), .req(req), .rdata(rdata),
  .phase_sensed_current_high(phase_sensed_current_high), .pulse_request(pulse_request),
  .pulse_start(pulse_start), .pulse_tristate(pulse_tristate), .regulation_ok(regulation_ok),
  .power_good_output(power_good_output), .conv_start(conv_start)
);

// ### tb/sense_model.sv
/*
  converter model: answers a start lat+1 cycles later with the channel level.
  assumes one start pulse per conversion and a held channel.
*/
`timescale 1ns/1ps
module sense_model (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // converter handshake
  input wire logic conv_start,
  input wire logic [1:0] conv_channel,
  output logic conv_done,
  output logic [7:0] conv_data,
  // levels and latency
  input wire logic [7:0] cur_val,
  input wire logic [7:0] volt_val,
  input wire logic [7:0] therm_val,
  input wire logic [3:0] lat
);
  logic [4:0] cnt;
  logic [7:0] pick;
  assign pick = conv_channel == 2'h0 ? cur_val : (conv_channel == 2'h1 ? volt_val : therm_val);
  // data toggles outside the done cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 5'h00;
      conv_done <= 1'b0;
      conv_data <= 8'h00;
    end else begin
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
      if (conv_start) begin
        cnt <= {1'b0, lat} + 5'h01;
      end else if (cnt == 5'h01) begin
        cnt <= 5'h00;
        conv_done <= 1'b1;
        conv_data <= pick;
      end else if (cnt != 5'h00) begin
        cnt <= cnt - 5'h01;
      end
    end
  end
endmodule // sense_model

// ### tb/phase_ocp_adc_monitor_tb_top.sv
/*
  self-checking bench for the phase limiter and monitor.
  assumes sense_model on the converter side and the bound checker.
*/
`timescale 1ns/1ps
`include "phase_ocp_regs.svh"
module phase_ocp_adc_monitor_tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  phase_ocp_pkg::reg_req_t req = '0;
  logic [7:0] rdata, rv, pstart, cdata;
  logic [7:0] cmp = 8'h00;
  logic [7:0] preq = 8'hff;
  logic [7:0] val [3] = '{8'h10, 8'h40, 8'h60};
  logic [15:0] gain;
  logic [3:0] lat = 4'h2;
  logic [1:0] ch;
  logic tri_st, pg, cs, done;
  logic reg_ok = 1'b0;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;

  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  phase_ocp_adc_monitor #(.SLOW_CYC(40), .FAST_CYC(20), .BOOST_CYC(10)) dut (
    .clk(clk), .rstn(rstn), .req(req), .rdata(rdata),
    .phase_sensed_current_high(cmp), .limit_gain(gain),
    .pulse_request(preq), .pulse_start(pstart), .pulse_tristate(tri_st),
    .regulation_ok(reg_ok), .power_good_output(pg), .conv_start(cs),
    .conv_channel(ch), .conv_done(done), .conv_data(cdata)
  );
  sense_model model (
    .clk(clk), .rstn(rstn), .conv_start(cs), .conv_channel(ch), .conv_done(done),
    .conv_data(cdata), .cur_val(val[0]), .volt_val(val[1]), .therm_val(val[2]), .lat(lat)
  );

  task automatic give_verdict();
    if (failures == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic do_reset();
    rstn = 1'b0;
    reg_ok = 1'b0;
    tick(6);
    rstn = 1'b1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick();
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    tick();
    req.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    tick();
    req.rd = 1'b1;
    req.addr = a;
    tick();
    req.rd = 1'b0;
    rv = rdata;
  endtask
  task automatic wait_for(input logic is_done, input logic [1:0] c);
    for (int i = 0; i < 400; i++) begin
      tick();
      if ((is_done ? done === 1'b1 : cs === 1'b1) && ch === c) return;
    end
    failures++;
    give_verdict();
  endtask
  task automatic gap(input logic [1:0] c, input int p);
    int t0;
    wait_for(1'b0, c);
    t0 = cyc;
    wait_for(1'b0, c);
    check("interval", 16'(cyc - t0 >= p - 6 && cyc - t0 <= p + 6), 16'h0001);
  endtask

  task automatic t_regs();
    check("gain reset", gain, {`RST_GAIN, `RST_GAIN});
    wr(`OFS_GAIN_LOW, 8'h5a);
    wr(`OFS_GAIN_HIGH, 8'ha5);
    check("gain", gain, 16'ha55a);
    rd(`OFS_GAIN_HIGH);
    check("gain high", rv, 8'ha5);
    wr(`OFS_CURRENT_RESULT, 8'h77);
    rd(`OFS_CURRENT_RESULT);
    check("result ro", rv, `RST_REG8);
    rd(8'h40);
    check("unmapped", rv, 8'h00);
  endtask

  task automatic t_adc();
    logic [7:0] e;
    int k;
    // threshold code compares raw counts: keep current results below it
    wr(`OFS_SUM_THRESHOLD, 8'h3f);
    tick(40);
    check("idle", cs, 1'b0);
    reg_ok = 1'b1;
    tick(4);
    check("pg up", pg, 1'b1);
    for (int c = 0; c < 3; c++) begin
      gap(2'(c), c == 0 ? 20 : 40);
      rd(`OFS_CURRENT_RESULT + 8'(c));
      check("result", rv, val[c]);
    end
    for (int c = 0; c < 3; c++) begin
      wr(`OFS_CURRENT_WINDOW + 8'(c), 8'(c + 1));
      // let the average settle on the new window before the step
      k = 0;
      rv = 8'h00;
      while (rv !== val[c] && k < 100) begin
        wait_for(1'b1, 2'(c));
        tick(2);
        rd(`OFS_CURRENT_RESULT + 8'(c));
        k++;
      end
      check("settled", rv, val[c]);
      e = val[c] + (8'h20 >> (c + 1));
      wait_for(1'b0, 2'(c));
      val[c] = val[c] + 8'h20;
      wait_for(1'b1, 2'(c));
      tick(2);
      rd(`OFS_CURRENT_RESULT + 8'(c));
      check("average", rv, e);
    end
  endtask

  task automatic t_limit();
    cmp = 8'h81;
    tick(9);
    check("start early", pstart, 8'hff);
    tick(5);
    check("start blocked", pstart, 8'h7e);
    check("pg in limit", pg, 1'b1);
    rd(`OFS_PHASE_FLAGS);
    check("flags", rv, 8'h81);
    for (int d = 1; d < 4; d++) begin
      wr(`OFS_LIMIT_DISABLE, 8'(d));
      check("start disabled", pstart, 8'hff);
      rd(`OFS_PHASE_FLAGS);
      check("flags disabled", rv, 8'h81);
    end
    wr(`OFS_LIMIT_DISABLE, 8'h00);
    check("start enabled", pstart, 8'h7e);
    cmp = 8'h00;
    tick(14);
    check("start released", pstart, 8'hff);
    rd(`OFS_PHASE_FLAGS);
    check("flags cleared", rv, 8'h00);
  endtask

  task automatic t_sum();
    int n;
    for (int code = 0; code < 4; code++) begin
      do_reset();
      val[0] = 8'h50;
      lat = 4'(code + 1);
      wr(`OFS_SUM_THRESHOLD, 8'h4f);
      wr(`OFS_SUM_DELAY, 8'(code));
      reg_ok = 1'b1;
      n = 0;
      while (tri_st !== 1'b1 && n < 9) begin
        wait_for(1'b0, 2'h0);
        wait_for(1'b1, 2'h0);
        n++;
        tick(3);
      end
      check("deglitch", 16'(n), 16'(1 << code));
      check("pg fault", pg, 1'b0);
      check("pulses off", pstart, 8'h00);
      check("tristate", tri_st, 1'b1);
      rd(`OFS_FAULT_STATUS);
      check("fault flag", rv[`BIT_SUM_FAULT], 1'b1);
      gap(2'h0, 10);
    end
  endtask

  initial begin
    do_reset();
    t_regs();
    t_adc();
    t_limit();
    t_sum();
    give_verdict();
  end
endmodule // phase_ocp_adc_monitor_tb_top
